// ==== hw/spi_dac_consts.svh ====
`ifndef SPI_DAC_CONSTS_SVH
`define SPI_DAC_CONSTS_SVH

// ----------------------------------------------------------------
// Code word layout
// ----------------------------------------------------------------
`define CODE_MSB      17
`define CODE_MID      18'h20000
`define CODE_ZERO     18'h00000
`define CODE_CLEAR    18'h00000

// ----------------------------------------------------------------
// Serial frame bit counting
// ----------------------------------------------------------------
`define FRAME_BITS    5'h12
`define BIT_ONE       5'h01
`define BIT_ZERO      5'h00

`endif

// ==== hw/spi_dac_input_control.sv ====
`timescale 1ns/1ps
`include "spi_dac_consts.svh"

// ----------------------------------------------------------------
// Summary of operation
// - Low latch load makes converter latch transparent
// - Reset loads midscale or zero by strap
// - Gain strap selects buffer gain one or two
// - Format strap: straight binary or twos complement
// - Low hardware reset restores strap reset code
// - High power-down request enters power-down
// - Shifting happens only while chip select low
// - Serial output released while chip select high
// - Stand-alone: input register shifted out serially
// - Daisy chain: shift register shifted out serially
// ----------------------------------------------------------------

module spi_dac_input_control (
    input  wire logic          clk_i,                   // System clock
    input  wire logic          rst_i,                   // Power-on reset
    input  wire logic          sclk_i,                  // Serial clock pin
    input  wire logic          cs_n_i,                  // Chip select pin
    input  wire logic          sdi_i,                   // Serial data in pin
    input  wire logic          latch_load_n_i,          // Latch load pin
    input  wire logic          reset_n_i,               // Hardware reset pin
    input  wire logic          power_down_request_i,    // Power-down pin
    input  wire logic          reset_code_select_i,     // Reset code strap
    input  wire logic          gain_select_i,           // Gain strap
    input  wire logic          code_format_select_i,    // Format strap
    input  wire logic          readout_source_select_i, // Readout strap
    output logic               sdo_o,                   // Serial data out
    output logic               sdo_oe_o,                // Serial out enable
    output spi_dac_pkg::code_t dac_code_o,              // Converter latch
    output logic               gain_two_o,              // Buffer gain is two
    output logic               power_down_o             // Output stage off
);
    import spi_dac_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------

    // Code loaded by any reset, picked by the strap
    function automatic code_t strap_code(input logic select_mid);
        strap_code = select_mid ? `CODE_MID : `CODE_ZERO;
    endfunction : strap_code

    // Converter latch always holds offset binary
    function automatic code_t to_offset_binary(input code_t word, input logic straight);
        to_offset_binary = straight ? word : {~word[`CODE_MSB], word[`CODE_MSB-1:0]};
    endfunction : to_offset_binary

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    link_state_t state;            // Frame sequencing state
    link_state_t next_state;       // Next frame state
    logic        sclk_prev;        // Serial clock one cycle ago
    logic        init_pending;     // Strap code still to be loaded
    logic        next_init_pending;
    code_t       input_reg;        // Input register
    code_t       next_input_reg;
    code_t       readout_reg;      // Stand-alone readout copy
    code_t       next_readout_reg;
    code_t       next_dac_code;
    logic        next_sdo;
    logic        next_sdo_oe;
    logic        next_gain_two;
    logic        next_power_down;
    logic        sclk_rise;        // Rising serial clock edge seen
    logic        sclk_fall;        // Falling serial clock edge seen
    logic        frame_start;      // First cycle with chip select low
    logic        load_strap;       // Any reset forces the strap code

    spi_shift_if sh ();            // Carrier to the shift engine

    // ----------------------------------------------------------------
    // Serial clock edge detection
    // ----------------------------------------------------------------

    // Pins are synchronous to clk_i, so one history flop is enough
    assign sclk_rise   = sclk_i & ~sclk_prev;
    assign sclk_fall   = ~sclk_i & sclk_prev;
    assign frame_start = (state != ST_FRAME) & ~cs_n_i;
    // Hardware reset pin and the post power-on load act alike
    assign load_strap  = ~reset_n_i | init_pending;

    // ----------------------------------------------------------------
    // Shift engine
    // ----------------------------------------------------------------

    // Bits are taken on rising serial edges, chip select low only
    assign sh.sample = sclk_rise & ~cs_n_i & reset_n_i;
    assign sh.sdi    = sdi_i;
    // A new frame or a hardware reset restarts the bit count
    assign sh.clear  = frame_start | ~reset_n_i;

    spi_shift_engine u_shift (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sh    (sh)
    );

    // ----------------------------------------------------------------
    // Frame sequencing
    // ----------------------------------------------------------------

    // Commit needs a whole word; a short frame is dropped silently
    always_comb begin
        next_state = state;
        if (!reset_n_i) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (!cs_n_i) begin
                        next_state = ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    // Chip select rise closes the frame
                    if (cs_n_i) begin
                        next_state = sh.frame_full ? ST_COMMIT : ST_IDLE;
                    end
                end
                ST_COMMIT: begin
                    next_state = cs_n_i ? ST_IDLE : ST_FRAME;
                end
                default: begin
                    // Recover from a corrupted one-hot code
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Input register and converter latch
    // ----------------------------------------------------------------

    // The strap is a level, so it is read by a clocked load after reset
    always_comb begin
        next_init_pending = 1'b0;
        next_input_reg    = input_reg;
        if (load_strap) begin
            next_input_reg = strap_code(reset_code_select_i);
        end else if (state == ST_COMMIT) begin
            // Format conversion happens once, on the way in
            next_input_reg = to_offset_binary(sh.shift_word,
                                              code_format_select_i);
        end
    end

    // Latch follows the input register as it is written, so no lag
    always_comb begin
        next_dac_code = dac_code_o;
        if (!latch_load_n_i || load_strap) begin
            next_dac_code = next_input_reg;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_pending <= 1'b1;
            input_reg    <= `CODE_ZERO;
            dac_code_o   <= `CODE_ZERO;
        end else begin
            init_pending <= next_init_pending;
            input_reg    <= next_input_reg;
            dac_code_o   <= next_dac_code;
        end
    end

    // ----------------------------------------------------------------
    // Serial readout
    // ----------------------------------------------------------------

    // Readout copy is frozen at frame start so a commit cannot tear it
    always_comb begin
        next_readout_reg = readout_reg;
        if (frame_start) begin
            next_readout_reg = input_reg;
        end else if (sh.sample) begin
            next_readout_reg = {readout_reg[`CODE_MSB-1:0], 1'b0};
        end
    end

    // Output changes on falling serial edges, ready for the next rise
    always_comb begin
        next_sdo_oe = ~cs_n_i;
        next_sdo    = sdo_o;
        if (cs_n_i) begin
            next_sdo = 1'b0;
        end else if (frame_start) begin
            next_sdo = readout_source_select_i ? input_reg[`CODE_MSB]
                                               : sh.shift_word[`CODE_MSB];
        end else if (sclk_fall) begin
            next_sdo = readout_source_select_i ? readout_reg[`CODE_MSB]
                                               : sh.shift_word[`CODE_MSB];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_prev   <= 1'b0;
            readout_reg <= `CODE_ZERO;
            sdo_o       <= 1'b0;
            sdo_oe_o    <= 1'b0;
        end else begin
            sclk_prev   <= sclk_i;
            readout_reg <= next_readout_reg;
            sdo_o       <= next_sdo;
            sdo_oe_o    <= next_sdo_oe;
        end
    end

    // ----------------------------------------------------------------
    // Analog stage controls
    // ----------------------------------------------------------------

    // Straps may move at any time; outputs follow a cycle later
    always_comb begin
        next_gain_two   = gain_select_i;
        next_power_down = power_down_request_i;
    end

    // Power-down leaves the codes alone; only the output stage shuts off
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_two_o   <= 1'b0;
            power_down_o <= 1'b0;
        end else begin
            gain_two_o   <= next_gain_two;
            power_down_o <= next_power_down;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A full frame closed by chip select rise
    sequence seq_frame_closed;
        state == ST_FRAME && cs_n_i && sh.frame_full && reset_n_i;
    endsequence

    // The commit cycle that follows, undisturbed by reset
    sequence seq_commit_cycle;
        state == ST_COMMIT && reset_n_i && !init_pending;
    endsequence

    a_latch_follows_input: assert property (
        !latch_load_n_i |=> dac_code_o == input_reg)
        else $error("latch did not follow input register");

    a_strap_reset_code: assert property (
        !reset_n_i |=> dac_code_o == strap_code($past(reset_code_select_i)))
        else $error("reset code does not match strap");

    a_gain_follows_strap: assert property (
        gain_select_i |=> gain_two_o ##1 (gain_two_o == $past(gain_select_i)))
        else $error("gain output wrong");

    a_straight_commit: assert property (
        seq_frame_closed ##1 (seq_commit_cycle and code_format_select_i)
        |=> input_reg == $past(sh.shift_word))
        else $error("straight binary word altered");

    a_hw_reset_state: assert property (
        !reset_n_i |=> input_reg == strap_code($past(reset_code_select_i))
                       && state == ST_IDLE && !sh.frame_full)
        else $error("hardware reset incomplete");

    a_power_down_follow: assert property (
        $rose(power_down_request_i) |=> power_down_o && $past(power_down_o) == 1'b0)
        else $error("power-down not entered");

    a_idle_no_shift: assert property (
        cs_n_i |=> $stable(sh.shift_word))
        else $error("shift register moved with chip select high");

    a_sdo_released: assert property (
        cs_n_i [*2] |-> !sdo_oe_o)
        else $error("serial output driven with chip select high");

    a_standalone_readout: assert property (
        (state == ST_FRAME && !cs_n_i && sclk_fall && readout_source_select_i)
        |=> sdo_o == $past(readout_reg[`CODE_MSB]))
        else $error("stand-alone readout bit wrong");

    a_daisy_readout: assert property (
        (state == ST_FRAME && !cs_n_i && sclk_fall && !readout_source_select_i)
        |=> sdo_o == $past(sh.shift_word[`CODE_MSB]))
        else $error("daisy chain bit wrong");

    a_commit_timing: assert property (
        seq_frame_closed ##1 seq_commit_cycle
        |=> input_reg == to_offset_binary($past(sh.shift_word),
                                          $past(code_format_select_i)))
        else $error("frame not committed two cycles after chip select rise");

    a_twos_msb_flip: assert property (
        seq_frame_closed ##1 (seq_commit_cycle and !code_format_select_i)
        |=> input_reg[`CODE_MSB] != $past(sh.shift_word[`CODE_MSB]))
        else $error("twos complement sign bit not inverted");

endmodule : spi_dac_input_control

// ==== hw/spi_dac_pkg.sv ====
// ----------------------------------------------------------------
// Shared types of the converter front end
// ----------------------------------------------------------------
package spi_dac_pkg;

    typedef logic [17:0] code_t;       // One converter code word
    typedef logic [4:0]  bit_count_t;  // Bits seen in the current frame

    // Frame sequencing, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,            // Chip select high
        ST_FRAME  = 3'b010,            // Chip select low, bits shifting
        ST_COMMIT = 3'b100             // Word moves to the input register
    } link_state_t;

endpackage : spi_dac_pkg

// ==== hw/spi_shift_engine.sv ====
`timescale 1ns/1ps
`include "spi_dac_consts.svh"

// ----------------------------------------------------------------
// Serial input shift register with saturating bit count
// ----------------------------------------------------------------
module spi_shift_engine (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    spi_shift_if.engine sh
);
    import spi_dac_pkg::*;

    code_t      shift_word;       // Shift register contents
    bit_count_t bit_count;        // Saturates at one full word
    code_t      next_shift_word;  // Next shift register contents
    bit_count_t next_bit_count;   // Next bit count

    // Next values: new bits enter at the bottom, old ones leave at the top
    always_comb begin
        next_shift_word = shift_word;
        next_bit_count  = bit_count;
        if (sh.sample) begin
            next_shift_word = {shift_word[`CODE_MSB-1:0], sh.sdi};
        end
        // A clear in the same cycle as a bit still counts that bit
        if (sh.clear) begin
            next_bit_count = sh.sample ? `BIT_ONE : `BIT_ZERO;
        end else if (sh.sample && bit_count != `FRAME_BITS) begin
            next_bit_count = bit_count + `BIT_ONE;
        end
    end

    // Registers only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_word <= `CODE_CLEAR;
            bit_count  <= `BIT_ZERO;
        end else begin
            shift_word <= next_shift_word;
            bit_count  <= next_bit_count;
        end
    end

    assign sh.shift_word = shift_word;
    // Longer frames keep the last word; the extra bits pass on downstream
    assign sh.frame_full = (bit_count == `FRAME_BITS);

endmodule : spi_shift_engine

// ==== hw/spi_shift_if.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link between frame control and the serial shift engine
// ----------------------------------------------------------------
interface spi_shift_if;
    import spi_dac_pkg::*;

    logic  sample;      // Take one serial bit this cycle
    logic  sdi;         // The serial bit
    logic  clear;       // Restart the bit count
    code_t shift_word;  // Last eighteen bits received
    logic  frame_full;  // A whole word has been received

    modport engine (input sample, input sdi, input clear,
                    output shift_word, output frame_full);
    modport owner  (output sample, output sdi, output clear,
                    input shift_word, input frame_full);
endinterface : spi_shift_if

// ==== tb/spi_dac_input_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end \
end

module spi_dac_input_control_tb;
    import spi_dac_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic  clk = 1'b0;      // 10 MHz system clock
    logic  rst = 1'b1;      // Power-on reset
    logic  sclk, cs_n, sdi; // Serial link, driven by the host model
    logic  latch_n = 1'b1;  // Latch load
    logic  reset_n = 1'b1;  // Hardware reset pin
    logic  pd      = 1'b0;  // Power-down request
    logic  rsel    = 1'b1;  // Reset code strap
    logic  gain    = 1'b0;  // Gain strap
    logic  fmt     = 1'b1;  // Format strap, straight binary
    logic  rdsel   = 1'b1;  // Readout strap, stand-alone
    logic  sdo, sdo_oe, gain_two, power_down;
    code_t dac_code;
    int    n_mismatch = 0, samples_checked = 0, cycles = 0;

    spi_dac_input_control dut_u (
        .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
        .latch_load_n_i(latch_n), .reset_n_i(reset_n), .power_down_request_i(pd),
        .reset_code_select_i(rsel), .gain_select_i(gain), .code_format_select_i(fmt),
        .readout_source_select_i(rdsel), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .dac_code_o(dac_code), .gain_two_o(gain_two), .power_down_o(power_down)
    );
    spi_host_model host_u (
        .clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi)
    );

    always #50 clk = ~clk;

    // Hang guard; the whole sequence needs about fifteen hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Shared steps
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Latch pulse issued only after the frame has closed
    task automatic load();
        @(posedge clk);
        latch_n <= 1'b0;
        tick(2);
        latch_n <= 1'b1;
        tick(2);
    endtask : load

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Both strap codes after power-on, then the hardware reset pin
    task automatic t_reset_codes();
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            rst  <= 1'b1;
            rsel <= s[0];
            tick(4);
            rst <= 1'b0;
            tick(3);
            `CHK("por code", s[0] ? 18'h20000 : 18'h00000, dac_code);
            host_u.send(36'h3FFFF, 18, 3);
            load();
            `CHK("written", 18'h3FFFF, dac_code);
            reset_n <= 1'b0;
            tick(2);
            reset_n <= 1'b1;
            tick(2);
            `CHK("pin code", s[0] ? 18'h20000 : 18'h00000, dac_code);
        end
    endtask : t_reset_codes

    // Latch holds while load is high, follows while it is low
    task automatic t_latch();
        host_u.send(36'h2ABCD, 18, 4);
        tick(3);
        `CHK("held", 18'h20000, dac_code);
        load();
        `CHK("loaded", 18'h2ABCD, dac_code);
        latch_n <= 1'b0;
        host_u.send(36'h01234, 18, 3);
        tick(2);
        `CHK("transparent", 18'h01234, dac_code);
        latch_n <= 1'b1;
    endtask : t_latch

    // Twos complement codes reach the latch with the top bit flipped
    task automatic t_twos();
        code_t w [2] = '{18'h1FFFF, 18'h20000};
        fmt <= 1'b0;
        foreach (w[i]) begin
            host_u.send({18'h0, w[i]}, 18, 3);
            load();
            `CHK("twos", w[i] ^ 18'h20000, dac_code);
        end
        fmt <= 1'b1;
    endtask : t_twos

    // Stand-alone readout returns the input register; enable only in frame
    task automatic t_standalone();
        host_u.send(36'h15A5A, 18, 3);
        fork
            host_u.send(36'h0, 18, 3);
            begin
                tick(5);
                `CHK("oe in frame", 1'b1, sdo_oe);
            end
        join
        `CHK("readback", 18'h15A5A, host_u.rx[17:0]);
        `CHK("oe idle", 1'b0, sdo_oe);
        `CHK("sdo idle", 1'b0, sdo);
    endtask : t_standalone

    // Daisy chain passes earlier bits on; stray clocks and short frames do nothing
    task automatic t_daisy();
        rdsel <= 1'b0;
        host_u.send({18'h2C3C3, 18'h0F0F0}, 36, 3);
        `CHK("chain old", 18'h00000, host_u.rx[35:18]);
        `CHK("chain pass", 18'h2C3C3, host_u.rx[17:0]);
        load();
        `CHK("chain last", 18'h0F0F0, dac_code);
        host_u.stray(8);
        host_u.send(36'h3C3C3, 18, 3);
        `CHK("no stray", 18'h0F0F0, host_u.rx[17:0]);
        load();
        host_u.send(36'h00155, 10, 3);
        load();
        `CHK("short drop", 18'h3C3C3, dac_code);
        rdsel <= 1'b1;
    endtask : t_daisy

    // Gain and power-down straps in all four combinations
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            gain <= i[0];
            pd   <= i[1];
            tick(3);
            `CHK("gain two", i[0], gain_two);
            `CHK("power down", i[1], power_down);
        end
    endtask : t_straps

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(4);
        rst <= 1'b0;
        tick(3);
        `CHK("por mid", 18'h20000, dac_code);
        t_reset_codes();
        t_latch();
        t_twos();
        t_standalone();
        t_daisy();
        t_straps();
        finish_test();
    end
endmodule : spi_dac_input_control_tb

// ==== tb/spi_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial host on the far side of the link
// ----------------------------------------------------------------
module spi_host_model (
    input  wire logic clk_i,   // System clock
    input  wire logic sdo_i,   // Serial data from the block
    output logic      sclk_o,  // Serial clock, still between frames except while stray toggles it
    output logic      cs_n_o,  // Chip select
    output logic      sdi_o    // Serial data to the block
);
    logic [35:0] rx;           // Bits seen on the serial output, last one lowest

    // Idle levels before the first frame
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
        rx     = '0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // One frame, first bit highest; half sets how slowly the clock toggles.
    // Half must be 2 or more so the block's falling-edge update has landed.
    task automatic send(input logic [35:0] data, input int nbits, input int half);
        int i;
        rx = '0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        wait_clk(half);
        for (i = nbits - 1; i >= 0; i--) begin
            sdi_o  <= data[i];
            sclk_o <= 1'b1;
            rx     = {rx[34:0], sdo_i};   // Read before this edge's updates
            wait_clk(half);
            sclk_o <= 1'b0;
            wait_clk(half);
        end
        cs_n_o <= 1'b1;
        sdi_o  <= ~sdi_o;                 // Released line shows no stale bit
        wait_clk(2);
    endtask : send

    // Clock and data wiggle while deselected; the block must not shift
    task automatic stray(input int n);
        repeat (n) begin
            @(posedge clk_i);
            sclk_o <= ~sclk_o;
            sdi_o  <= ~sdi_o;
        end
    endtask : stray
endmodule : spi_host_model
